// ==== tb/ppom_periph.sv ====
`timescale 1ns/10ps
// peripheral side: override bundle launched just after each core clock edge
module ppom_periph
    import ppom_pkg::*;
(
    input  wire logic      i_clk,
    input  wire ppom_ovr_s i_req,
    output ppom_ovr_s      o_ovr
);
    // overrides change on the clock like real peripheral registers
    always_ff @(posedge i_clk) begin
        o_ovr <= i_req;
    end
endmodule

// ==== tb/ppom_port_mux_chk.sv ====
`timescale 1ns/10ps
// watches override selects and latch updates at the top ports
module ppom_port_mux_chk
    import ppom_pkg::*;
(
    input wire logic       I_CORE_CLK,
    input wire logic       I_SRST,
    input wire logic       I_GLOBAL_PULLUP_DISABLE,
    input wire logic       I_SLEEP_CLAMP,
    input wire logic       I_EXT_EXTERNAL_INTERRUPT1_INPUT_ENABLE,
    input wire logic       I_ANALOG_REF_ON_PIN,
    input wire logic       I_PORT_DATA_WRITE_STROBE,
    input wire logic       I_PORT_PIN_WRITE_STROBE,
    input wire logic       I_PORT_DIR_WRITE_STROBE,
    input wire logic [7:0] I_WRITE_DATA,
    input wire ppom_ovr_s  I_OVR,
    input wire ppom_pad_s  O_PAD,
    input wire logic [7:0] O_PIN_DIRECTION,
    input wire logic [7:0] O_PIN_OUTPUT_LATCH
);
    logic [7:0] pe, pv, de, dv, ve, vv, te, ne, nv, l, d, rm, e_pu, e_oe, e_pv, e_ie;
    // expected pad controls from present state and overrides
    assign {pe, pv, de, dv, ve, vv, te, ne, nv} = I_OVR;
    assign l = O_PIN_OUTPUT_LATCH;
    assign d = O_PIN_DIRECTION;
    assign rm = {4'h0, I_ANALOG_REF_ON_PIN, 3'h0};
    assign e_pu = (pe & pv | ~pe & ~d & l & {8{~I_GLOBAL_PULLUP_DISABLE}}) & ~rm;
    assign e_oe = (de & dv | ~de & d) & ~rm;
    assign e_pv = ve & vv | ~ve & l;
    assign e_ie = ne & nv | ~ne & ({8{~I_SLEEP_CLAMP}} | {5'h0, I_EXT_EXTERNAL_INTERRUPT1_INPUT_ENABLE, 2'h0});
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_SRST);
    a_pullup_sel: assert property (
        !$past(I_SRST) |-> O_PAD.pad_pullup == $past(e_pu)) else $error("pull-up select");
    a_drive_sel: assert property (
        !$past(I_SRST) |-> O_PAD.pad_oe == $past(e_oe)) else $error("driver enable select");
    a_value_sel: assert property (!$past(I_SRST) |->
        (O_PAD.pad_out & O_PAD.pad_oe) == ($past(e_pv) & O_PAD.pad_oe)) else $error("pad value");
    a_inen_sel: assert property (
        !$past(I_SRST) |-> O_PAD.input_enable == $past(e_ie)) else $error("input enable select");
    // reset cycles are left out so a reset edge is never read as a write
    a_data_write: assert property (
        !I_SRST && I_PORT_DATA_WRITE_STROBE |=> l == $past(I_WRITE_DATA))
        else $error("latch write");
    a_dir_write: assert property (
        !I_SRST && I_PORT_DIR_WRITE_STROBE |=> d == $past(I_WRITE_DATA))
        else $error("direction write");
    a_pin_toggle: assert property (
        !I_SRST && I_PORT_PIN_WRITE_STROBE && !I_PORT_DATA_WRITE_STROBE && te == 8'h00
        |=> l == $past(l ^ I_WRITE_DATA)) else $error("pin write toggle");
    a_ovr_toggle: assert property (
        !I_SRST && !I_PORT_PIN_WRITE_STROBE && !I_PORT_DATA_WRITE_STROBE
        |=> l == $past(l ^ te)) else $error("toggle override");
endmodule
bind ppom_port_mux ppom_port_mux_chk ppom_port_mux_chk_inst (.I_CORE_CLK, .I_SRST,
    .I_GLOBAL_PULLUP_DISABLE, .I_SLEEP_CLAMP, .I_EXT_EXTERNAL_INTERRUPT1_INPUT_ENABLE, .I_ANALOG_REF_ON_PIN,
    .I_PORT_DATA_WRITE_STROBE, .I_PORT_PIN_WRITE_STROBE, .I_PORT_DIR_WRITE_STROBE,
    .I_WRITE_DATA, .I_OVR, .O_PAD, .O_PIN_DIRECTION, .O_PIN_OUTPUT_LATCH);

// ==== tb/tb.sv ====
`timescale 1ns/10ps
// directed checks of the port override mux
module tb
    import ppom_pkg::*;
;
    logic       clk, srst, global_pullup_disable, clamp, external_interrupt1_input, external_analog_reference, sd, sr, sp, eint, sck, sdi, cap;
    logic [7:0] wd, pad_in, pir, pdir, plat, pcs;
    ppom_ovr_s  req, ovr;
    ppom_pad_s  pad;
    int         fail_count, num_checks;
    // 25 MHz clock
    always #20 clk = ~clk;
    ppom_periph ppom_periph_inst (.i_clk(clk), .i_req(req), .o_ovr(ovr));
    ppom_port_mux ppom_port_mux_inst (.I_CORE_CLK(clk), .I_SRST(srst),
        .I_GLOBAL_PULLUP_DISABLE(global_pullup_disable), .I_SLEEP_CLAMP(clamp), .I_EXT_EXTERNAL_INTERRUPT1_INPUT_ENABLE(external_interrupt1_input),
        .I_ANALOG_REF_ON_PIN(external_analog_reference), .I_PORT_DATA_WRITE_STROBE(sd), .I_PORT_DIR_WRITE_STROBE(sr),
        .I_PORT_PIN_WRITE_STROBE(sp), .I_WRITE_DATA(wd), .I_OVR(ovr), .I_PAD_IN(pad_in),
        .O_PAD(pad), .O_PIN_INPUT_REGISTER(pir), .O_PIN_DIRECTION(pdir),
        .O_PIN_OUTPUT_LATCH(plat), .O_PIN_CHANGE_SOURCE(pcs), .O_EXTERNAL_INTERRUPT1_INPUT(eint),
        .O_SERIAL_IFACE_CLOCK(sck), .O_SERIAL_DATA_INPUT(sdi), .O_TIMER0_CAPTURE_INPUT(cap));
    // compare one value and count it
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("Error %0t: got %h want %h", $time, s, e);
        end
    endtask
    // wait n edges, then sample away from the edge
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    // one strobe for one cycle: 0 latch, 1 direction, 2 pin toggle
    task automatic wr(input int k, input logic [7:0] v);
        @(posedge clk);
        {sd, sr, sp} <= {k == 0, k == 1, k == 2};
        wd <= v;
        @(posedge clk);
        {sd, sr, sp} <= 3'h0;
    endtask
    task automatic report_and_stop();
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // hang guard: the sequence needs under 100 cycles
    initial begin
        repeat (2000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end
    // main sequence
    initial begin
        {clk, global_pullup_disable, clamp, external_interrupt1_input, external_analog_reference, sd, sr, sp} = '0;
        {srst, wd, pad_in, req, fail_count, num_checks} = {1'b1, 16'h0, 72'h0, 64'h0};
        repeat (3) @(posedge clk);
        srst <= 0;
        wr(1, 8'h0f);
        wr(0, 8'h15);
        settle(3);
        chk(pdir, 8'h0f);
        chk(pad.pad_oe, 8'h0f);
        chk(pad.pad_out & pad.pad_oe, 8'h05);
        chk(pad.pad_pullup, 8'h10);
        chk(pad.input_enable, 8'hff);
        wr(2, 8'h81);
        settle(2);
        chk(plat, 8'h94);
        @(posedge clk);
        req <= {8'hff, 8'h0f, 8'hf0, 8'ha0, 8'hff, 8'h5a, 8'h00, 8'h0f, 8'h05};
        clamp <= 1;
        settle(3);
        chk(pad.pad_pullup, 8'h0f);
        chk(pad.pad_oe, 8'haf);
        chk(pad.pad_out & pad.pad_oe, 8'h0a);
        chk(pad.input_enable, 8'h05);
        @(posedge clk);
        external_analog_reference <= 1;
        settle(2);
        chk(pad.pad_pullup | pad.pad_oe, 8'ha7);
        @(posedge clk);
        {external_analog_reference, external_interrupt1_input, global_pullup_disable} <= 3'h3;
        req <= {48'h0, 8'h01, 16'h0};
        @(posedge clk);
        req <= '0;
        settle(3);
        chk(plat, 8'h95);
        chk(pad.input_enable, 8'h04);
        chk(pad.pad_pullup, 8'h00);
        @(posedge clk);
        {clamp, external_interrupt1_input} <= 2'h0;
        pad_in <= 8'h91;
        settle(5);
        chk(pcs, 8'h91);
        chk(pad.alt_function_digital_input, 8'h91);
        chk(pir, 8'h91);
        chk({4'h0, sck, eint, sdi, cap}, 8'h03);
        // clamped port with the interrupt pin kept awake: only bit 2 gets through
        @(posedge clk);
        {clamp, external_interrupt1_input} <= 2'h3;
        pad_in <= 8'h6e;
        settle(3);
        chk(pad.input_enable, 8'h04);
        chk(pcs, 8'h04);
        chk(pad.alt_function_digital_input, 8'h04);
        chk(pir, 8'h04);
        chk({4'h0, sck, eint, sdi, cap}, 8'h0c);
        // mid-run reset clears the port registers, then the input path resumes
        @(posedge clk);
        srst <= 1'b1;
        settle(1);
        chk(plat, 8'h00);
        chk(pdir, 8'h00);
        chk(pad.pad_oe, 8'h00);
        @(posedge clk);
        srst <= 1'b0;
        settle(2);
        chk(pcs, 8'h04);
        report_and_stop();
    end
endmodule

// ==== verilog/ppom_pkg.sv ====
package ppom_pkg;
    localparam int PPOM_WIDTH = 8;
    localparam logic [7:0] PPOM_PORT_RESET = 8'h00;
    localparam int PPOM_EXTERNAL_ANALOG_REFERENCE_BIT = 3;
    localparam int PPOM_CLK_BIT = 2;
    localparam int PPOM_DOUT_BIT = 1;
    localparam int PPOM_DIN_BIT = 0;
    localparam int PPOM_CAPT_BIT = 4;
    localparam logic [1:0] PPOM_SYNC_RESET = 2'h0;
    // {direction, latch, pull-up disable} code that turns the default pull-up on
    localparam logic [2:0] PPOM_PU_ON = 3'h2;

    // per-pin alternate-function override bundle
    typedef struct packed {
        logic [7:0] pullup_override_enable;
        logic [7:0] pullup_override_value;
        logic [7:0] direction_override_enable;
        logic [7:0] direction_override_value;
        logic [7:0] port_value_override_enable;
        logic [7:0] port_value_override_value;
        logic [7:0] port_toggle_override_enable;
        logic [7:0] input_enable_override_enable;
        logic [7:0] input_enable_override_value;
    } ppom_ovr_s;

    // register state of the port
    typedef struct packed {
        logic [7:0] pin_direction_bit;
        logic [7:0] pin_output_latch_bit;
        logic [7:0] sync_first;
        logic [7:0] pin_input_register_bit;
    } ppom_regs_s;

    // pad-facing and alternate-function outputs
    typedef struct packed {
        logic [7:0] pad_out;
        logic [7:0] pad_oe;
        logic [7:0] pad_pullup;
        logic [7:0] input_enable;
        logic [7:0] alt_function_digital_input;
    } ppom_pad_s;
endpackage

// ==== verilog/ppom_port_mux.sv ====
`timescale 1ns/10ps
// Behaviour
// - pull-up follows override value if enabled, else on when dir0, latch1, disable0
// - pull-up override ignores direction, latch and global disable
// - driver enable from direction override value if enabled, else direction bit
// - direction override value one enables driver regardless of direction bit
// - driven value from port value override if enabled, else output latch
// - port value override value reaches pad regardless of latch
// - toggle override inverts the output latch bit
// - input enable from override value if enabled, else sleep clamp state
// - input enable override ignores sleep mode
// - alternate input taken after Schmitt trigger, before port synchroniser
// - port strobes shared by all pins; clock, clamp, pull-up disable global
// - bit 3 as analog reference disables pull-up and driver
// - bit 2 carries external interrupt 1 and serial clock
// - bit 1 serial data out; bit 0 serial data in and two-wire data (only bit 0 serial data in is brought out here)
// - bit 4 feeds timer 0 capture and ADC channel 3 (here only timer 0 capture; no ADC output)
// - bit n feeds pin-change source n; ADC channel mapping per bit (no ADC outputs here)
// - without overrides, direction one drives latch, zero is input
// - writing one to input register toggles the output latch
// - sleep clamps inputs unless override or external interrupt keeps them
module ppom_port_mux
    import ppom_pkg::*;
#(
    parameter int WIDTH = PPOM_WIDTH
) (
    input  wire logic             I_CORE_CLK,
    input  wire logic             I_SRST,
    input  wire logic             I_GLOBAL_PULLUP_DISABLE,
    input  wire logic             I_SLEEP_CLAMP,
    input  wire logic             I_EXT_EXTERNAL_INTERRUPT1_INPUT_ENABLE,
    input  wire logic             I_ANALOG_REF_ON_PIN,
    input  wire logic             I_PORT_DATA_WRITE_STROBE,
    input  wire logic             I_PORT_DIR_WRITE_STROBE,
    input  wire logic             I_PORT_PIN_WRITE_STROBE,
    input  wire logic [WIDTH-1:0] I_WRITE_DATA,
    input  wire ppom_ovr_s        I_OVR,
    input  wire logic [WIDTH-1:0] I_PAD_IN,
    output ppom_pad_s             O_PAD,
    output logic      [WIDTH-1:0] O_PIN_INPUT_REGISTER,
    output logic      [WIDTH-1:0] O_PIN_DIRECTION,
    output logic      [WIDTH-1:0] O_PIN_OUTPUT_LATCH,
    output logic      [WIDTH-1:0] O_PIN_CHANGE_SOURCE,
    output logic                  O_EXTERNAL_INTERRUPT1_INPUT,
    output logic                  O_SERIAL_IFACE_CLOCK,
    output logic                  O_SERIAL_DATA_INPUT,
    output logic                  O_TIMER0_CAPTURE_INPUT
);
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] latch;
        logic [7:0] alt_in;
        logic [7:0] pin_change;
        logic       ext_external_interrupt1_input;
        logic       serial_iface_clock;
        logic       sdi;
        logic       capt;
        logic [7:0] pad_out;
        logic [7:0] pad_oe;
        logic [7:0] pad_pullup;
        logic [7:0] input_enable;
    } ppom_state_s;

    ppom_state_s      st;
    ppom_state_s      next_st;
    logic [WIDTH-1:0] synced;
    logic [WIDTH-1:0] schmitt_out;
    logic [WIDTH-1:0] in_en;
    logic [WIDTH-1:0] keep_alive;
    logic [WIDTH-1:0] oe_c;
    logic [WIDTH-1:0] out_c;
    logic [WIDTH-1:0] pu_c;
    logic [WIDTH-1:0] latch_c;

    // per-pin control path, combinational selects
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_pin
            // external interrupt keeps bit 2 awake in sleep
            assign keep_alive[gi] = (gi == PPOM_CLK_BIT) ? I_EXT_EXTERNAL_INTERRUPT1_INPUT_ENABLE : 1'b0;
            assign in_en[gi] = I_OVR.input_enable_override_enable[gi]
                             ? I_OVR.input_enable_override_value[gi]
                             : (!I_SLEEP_CLAMP || keep_alive[gi]);
            // clamp to ground ahead of the Schmitt trigger
            assign schmitt_out[gi] = I_PAD_IN[gi] & in_en[gi];
            // output latch with toggle from override or input register write
            assign latch_c[gi] = st.latch[gi]
                ^ I_OVR.port_toggle_override_enable[gi]
                ^ (I_PORT_PIN_WRITE_STROBE & I_WRITE_DATA[gi]);
            assign oe_c[gi] = (I_ANALOG_REF_ON_PIN && gi == PPOM_EXTERNAL_ANALOG_REFERENCE_BIT) ? 1'b0
                : I_OVR.direction_override_enable[gi]
                ? I_OVR.direction_override_value[gi]
                : st.dir[gi];
            assign out_c[gi] = I_OVR.port_value_override_enable[gi]
                ? I_OVR.port_value_override_value[gi]
                : st.latch[gi];
            assign pu_c[gi] = (I_ANALOG_REF_ON_PIN && gi == PPOM_EXTERNAL_ANALOG_REFERENCE_BIT) ? 1'b0
                : I_OVR.pullup_override_enable[gi]
                ? I_OVR.pullup_override_value[gi]
                : ({st.dir[gi], st.latch[gi], I_GLOBAL_PULLUP_DISABLE} == PPOM_PU_ON);
        end
    endgenerate

    // port synchroniser feeding the input register
    ppom_sync #(
        .WIDTH (WIDTH)
    ) u_sync (
        .i_clk   (I_CORE_CLK),
        .i_srst  (I_SRST),
        .i_async (schmitt_out),
        .o_sync  (synced)
    );

    // next-state: shared strobes load all bits of the port at once
    always_comb begin
        next_st = st;
        if (I_PORT_DIR_WRITE_STROBE) begin
            next_st.dir = I_WRITE_DATA;
        end
        if (I_PORT_DATA_WRITE_STROBE) begin
            next_st.latch = I_WRITE_DATA;
        end else begin
            next_st.latch = latch_c;
        end
        next_st.alt_in       = schmitt_out;
        next_st.pin_change   = schmitt_out;
        next_st.ext_external_interrupt1_input     = schmitt_out[PPOM_CLK_BIT];
        next_st.serial_iface_clock         = schmitt_out[PPOM_CLK_BIT];
        next_st.sdi          = schmitt_out[PPOM_DIN_BIT];
        next_st.capt         = schmitt_out[PPOM_CAPT_BIT];
        next_st.pad_out      = out_c;
        next_st.pad_oe       = oe_c;
        next_st.pad_pullup   = pu_c;
        next_st.input_enable = in_en;
    end

    // state register
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flip-flops
    assign O_PAD.pad_out                    = st.pad_out;
    assign O_PAD.pad_oe                     = st.pad_oe;
    assign O_PAD.pad_pullup                 = st.pad_pullup;
    assign O_PAD.input_enable               = st.input_enable;
    assign O_PAD.alt_function_digital_input = st.alt_in;
    assign O_PIN_INPUT_REGISTER             = synced;
    assign O_PIN_DIRECTION                  = st.dir;
    assign O_PIN_OUTPUT_LATCH               = st.latch;
    assign O_PIN_CHANGE_SOURCE              = st.pin_change;
    assign O_EXTERNAL_INTERRUPT1_INPUT      = st.ext_external_interrupt1_input;
    assign O_SERIAL_IFACE_CLOCK             = st.serial_iface_clock;
    assign O_SERIAL_DATA_INPUT              = st.sdi;
    assign O_TIMER0_CAPTURE_INPUT           = st.capt;
endmodule

// ==== verilog/ppom_sync.sv ====
`timescale 1ns/10ps
// two-flop synchroniser, one per port bit
module ppom_sync
    import ppom_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_srst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;

    // first stage read only by the second
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            stage1 <= '0;
            o_sync <= '0;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule
